// File: hw/loop_diag_pkg.sv
package loop_diag_pkg;

    // Widths of the counters and of the display
    localparam int unsigned SW_W = 8;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned IDLE_W = 16;
    localparam int unsigned LED_W = 16;

    // Number of single-byte counters in each bank
    localparam int unsigned EVT_NUM = 13;
    localparam int unsigned ERR_NUM = 17;

    // Switch addresses of the counter groups
    localparam logic [7:0] ADDR_EVT_FIRST = 8'h30;
    localparam logic [7:0] ADDR_NIBBLES = 8'h32;
    localparam logic [7:0] ADDR_EVT_LAST = 8'h3D;
    localparam logic [7:0] ADDR_IDLE = 8'h3E;
    localparam logic [7:0] ADDR_ERR_SUM = 8'h40;
    localparam logic [7:0] ADDR_ERR_FIRST = 8'h41;
    localparam logic [7:0] ADDR_ERR_LAST = 8'h51;
    localparam logic [7:0] ADDR_STEP = 8'h01;

    // Event strobe bit positions (0x30..0x3D, 0x32 excluded)
    localparam int unsigned EV_TX_TOTAL = 0;
    localparam int unsigned EV_TX_RETRY = 1;
    localparam int unsigned EV_HOST_TX_TAKEN = 2;
    localparam int unsigned EV_HOST_RX_STORED = 3;
    localparam int unsigned EV_HOST_IRQ = 4;
    localparam int unsigned EV_HP_TX = 5;
    localparam int unsigned EV_HP_RX = 6;
    localparam int unsigned EV_HOST_CMD = 7;
    localparam int unsigned EV_HOST_TX_MISS = 8;
    localparam int unsigned EV_SPURIOUS_NMI = 9;
    localparam int unsigned EV_IRQ_MSG_SENT = 10;
    localparam int unsigned EV_OFFLINE_DROP = 11;
    localparam int unsigned EV_IRQ_MSG_TIMEOUT = 12;

    // Hard error strobe bit positions (address 0x41 + position)
    localparam int unsigned ER_NMI_UNRESOLVED = 0;
    localparam int unsigned ER_IRQ_UNRESOLVED = 1;
    localparam int unsigned ER_TIMER_UNRESOLVED = 2;
    localparam int unsigned ER_QUEUE_OVERFLOW = 3;
    localparam int unsigned ER_CHECKSUM = 4;
    localparam int unsigned ER_HOST_IRQ_UNRESOLVED = 5;
    localparam int unsigned ER_SEQUENCE = 6;
    localparam int unsigned ER_HEADER_CRC = 7;
    localparam int unsigned ER_DATA_CRC = 8;
    localparam int unsigned ER_DATA_CRC_EN_ROUTE = 9;
    localparam int unsigned ER_TX_FAIL = 10;
    localparam int unsigned ER_WATCHDOG = 11;
    localparam int unsigned ER_DATA_LENGTH = 12;
    localparam int unsigned ER_LOOP1_RX = 13;
    localparam int unsigned ER_LOOP2_RX = 14;
    localparam int unsigned ER_LOOP1_TX = 15;
    localparam int unsigned ER_LOOP2_TX = 16;

    // Values after reset
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
    localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
    localparam logic [LED_W-1:0] LED_RST = 16'h0000;

endpackage

// File: hw/counter_bank_if.sv
`timescale 1ns/10ps
// Increment strobes in, counter values out, for one bank
interface counter_bank_if #(
    parameter int unsigned N = 1,
    parameter int unsigned W = 8
);
    logic [N-1:0] bump;
    logic [N-1:0][W-1:0] count;

    modport bank (
        input bump,
        output count
    );
    modport user (
        output bump,
        input count
    );
endinterface

// File: hw/byte_counter_bank.sv
`timescale 1ns/10ps
module byte_counter_bank #(
    parameter int unsigned N = 1,
    parameter int unsigned W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Strobes and values
    counter_bank_if.bank cb
);

    if (N < 1 || W < 1) begin : g_bad_size
        $error("byte_counter_bank needs at least one counter of at least one bit");
    end

    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
    } bank_s;

    bank_s state_q;
    bank_s state_d;

    // Each strobed counter steps by one and wraps at the top
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < N; i++) begin
            if (cb.bump[i]) begin
                state_d.cnt[i] = state_q.cnt[i] + W'(1);
            end
        end
    end

    // Cleared on reset so every counter starts from zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign cb.count = state_q.cnt;

endmodule

// File: hw/loop_diag_counter_bank.sv
`timescale 1ns/10ps
// How it works
// - Switch value 30..3E or 40..51 addresses one counter for viewing; other values show zero.
// - 30 all sent, 31 retries, 33 host transmit taken, 36 priority sent, 39 missed.
// - 34 stored in host receive buffer, 37 priority messages received.
// - 32 holds receive and transmit nibbles, receive on LEDs 7..4, transmit on LEDs 3..0.
// - 35 host interrupt requests, 3B request messages sent, 3D request timer expiries.
// - 3A counts spurious non-maskable interrupts from address present.
// - 38 host commands, 3C messages dropped for off-line destination.
// - 3E counts idle level passes, sixteen bits wide.
// - 40 reloads each handshake period with the sum of other error counters.
// - 41, 42, 43, 46 count unresolved interrupts of each kind.
// - 44 queue overflow, 45 checksum, 47 sequence, 4D data length.
// - 48 header CRC, 49 data CRC, 4A data CRC picked up en route.
// - 4B transmission failures, 4C watchdog expirations.
// - 4E, 4F loop receive failures; 50, 51 loop transmit failures.
// - Error counters step only on hard error strobes.
// - LEDs show the currently addressed counter.
module loop_diag_counter_bank
    import loop_diag_pkg::*;
#(
    parameter int unsigned EVT_N = EVT_NUM,
    parameter int unsigned ERR_N = ERR_NUM
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Counter address from the option switch
    input wire logic [SW_W-1:0] address_select_switch,
    // Operational event strobes, one cycle each
    input wire logic [EVT_N-1:0] event_strobe,
    input wire logic host_rx_strobe,
    input wire logic host_tx_strobe,
    input wire logic idle_pass_strobe,
    // Hard error strobes, one cycle each
    input wire logic [ERR_N-1:0] hard_error_strobe,
    // Handshake period tick
    input wire logic handshake_tick,
    // Front panel indicators
    output logic [LED_W-1:0] panel_led
);

    // The address map is fixed, so only the documented bank sizes fit
    if (EVT_N != EVT_NUM || ERR_N != ERR_NUM) begin : g_bad_size
        $error("loop_diag_counter_bank bank sizes must match the fixed address map");
    end

    typedef struct packed {
        logic [NIB_W-1:0] host_rx;
        logic [NIB_W-1:0] host_tx;
        logic [IDLE_W-1:0] idle_passes;
        logic [BYTE_W-1:0] err_sum;
        logic [LED_W-1:0] led;
    } diag_s;

    diag_s state_q;
    diag_s state_d;

    counter_bank_if #(.N(EVT_NUM), .W(BYTE_W)) evt_cb ();
    counter_bank_if #(.N(ERR_NUM), .W(BYTE_W)) err_cb ();

    // Ordinary traffic and host handshake events
    assign evt_cb.bump = event_strobe;

    // Only hard error sources reach the error bank
    assign err_cb.bump = hard_error_strobe;

    byte_counter_bank #(
        .N(EVT_NUM),
        .W(BYTE_W)
    ) u_evt_bank (
        .clock(clock),
        .rst_n(rst_n),
        .cb(evt_cb)
    );

    byte_counter_bank #(
        .N(ERR_NUM),
        .W(BYTE_W)
    ) u_err_bank (
        .clock(clock),
        .rst_n(rst_n),
        .cb(err_cb)
    );

    // Sum of the individual error counters, wrapping at one byte
    logic [BYTE_W-1:0] err_total;

    always_comb begin
        err_total = BYTE_RST;
        for (int i = 0; i < ERR_NUM; i++) begin
            err_total = err_total + err_cb.count[i];
        end
    end

    // Slot offsets for the two banks, derived from the switch
    logic [SW_W-1:0] evt_off;
    logic [SW_W-1:0] evt_slot;
    logic [SW_W-1:0] err_slot;

    always_comb begin
        evt_off = address_select_switch - ADDR_EVT_FIRST;
        // 0x32 is not in the byte bank, so later addresses close the gap
        if (address_select_switch > ADDR_NIBBLES) begin
            evt_slot = evt_off - ADDR_STEP;
        end else begin
            evt_slot = evt_off;
        end
        err_slot = address_select_switch - ADDR_ERR_FIRST;
    end

    // Value shown for the addressed counter
    logic [LED_W-1:0] view;

    always_comb begin
        view = LED_RST;
        if (address_select_switch == ADDR_NIBBLES) begin
            view = {{(LED_W - 2 * NIB_W){1'b0}}, state_q.host_rx, state_q.host_tx};
        end else if (address_select_switch >= ADDR_EVT_FIRST && address_select_switch <= ADDR_EVT_LAST) begin
            view = {{(LED_W - BYTE_W){1'b0}}, evt_cb.count[evt_slot]};
        end else if (address_select_switch == ADDR_IDLE) begin
            view = state_q.idle_passes;
        end else if (address_select_switch == ADDR_ERR_SUM) begin
            view = {{(LED_W - BYTE_W){1'b0}}, state_q.err_sum};
        end else if (address_select_switch >= ADDR_ERR_FIRST && address_select_switch <= ADDR_ERR_LAST) begin
            view = {{(LED_W - BYTE_W){1'b0}}, err_cb.count[err_slot]};
        end
    end

    // Next state of the local counters and the display
    always_comb begin
        state_d = state_q;
        // Receive and transmit nibbles step apart and wrap at 16
        if (host_rx_strobe) begin
            state_d.host_rx = state_q.host_rx + NIB_W'(1);
        end
        if (host_tx_strobe) begin
            state_d.host_tx = state_q.host_tx + NIB_W'(1);
        end
        if (idle_pass_strobe) begin
            state_d.idle_passes = state_q.idle_passes + IDLE_W'(1);
        end
        // Sampled only on the tick, so it lags the live counters by design
        if (handshake_tick) begin
            state_d.err_sum = err_total;
        end
        state_d.led = view;
    end

    // Single register stage for all local state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q.host_rx <= NIB_RST;
            state_q.host_tx <= NIB_RST;
            state_q.idle_passes <= IDLE_RST;
            state_q.err_sum <= BYTE_RST;
            state_q.led <= LED_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // LEDs come straight from the display register
    assign panel_led = state_q.led;

endmodule

// File: tb/loop_diag_checker.sv
`timescale 1ns/10ps
module loop_diag_checker
    import loop_diag_pkg::*;
#(
    parameter int unsigned EVT_N = EVT_NUM,
    parameter int unsigned ERR_N = ERR_NUM
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bank inputs
    input wire logic [SW_W-1:0] address_select_switch,
    input wire logic [EVT_N-1:0] event_strobe,
    input wire logic host_rx_strobe,
    input wire logic host_tx_strobe,
    input wire logic idle_pass_strobe,
    input wire logic [ERR_N-1:0] hard_error_strobe,
    input wire logic handshake_tick,
    // Display
    input wire logic [LED_W-1:0] panel_led
);
    logic [7:0] sw;
    logic is_byte;
    logic hit;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Own strobe of the viewed byte counter; only meaningful when is_byte
    always_comb begin
        sw = address_select_switch;
        is_byte = (sw >= 8'h30 && sw <= 8'h3D && sw != 8'h32) || (sw >= 8'h41 && sw <= 8'h51);
        if (sw[7:4] == 4'h3) begin
            hit = event_strobe[(sw < 8'h32) ? sw[3:0] : sw[3:0] - 4'h1];
        end else begin
            hit = hard_error_strobe[sw - 8'h41];
        end
    end
    // Cause seen while the view stays put for the two edges the display lags
    sequence s_view(c);
        c && $stable(address_select_switch) ##1 $stable(address_select_switch);
    endsequence
    AST_RST: assert property (disable iff (1'b0) !rst_n |=> panel_led == LED_RST)
        else $error("display not cleared in reset");
    AST_UNUSED: assert property ((sw < 8'h30 || sw == 8'h3F || sw > 8'h51) |=> panel_led == 16'h0000)
        else $error("unassigned address not zero");
    AST_BYTE_UPPER: assert property (is_byte |=> panel_led[15:8] == 8'h00)
        else $error("byte counter upper bits set");
    AST_BYTE_STEP: assert property (
        s_view(is_byte && hit) |=> panel_led[7:0] == $past(panel_led[7:0]) + 8'h01)
        else $error("counter did not step by one");
    AST_BYTE_HOLD: assert property (s_view(is_byte && !hit) |=> $stable(panel_led))
        else $error("counter moved without its strobe");
    AST_NIBBLE: assert property (
        s_view(sw == ADDR_NIBBLES && host_rx_strobe && !host_tx_strobe)
        |=> panel_led[7:4] == $past(panel_led[7:4]) + 4'h1 && $stable(panel_led[3:0]))
        else $error("receive nibble wrong");
    AST_IDLE: assert property (
        s_view(sw == ADDR_IDLE && idle_pass_strobe) |=> panel_led == $past(panel_led) + 16'h0001)
        else $error("idle count wrong");
    AST_SUM_HOLD: assert property (s_view(sw == ADDR_ERR_SUM && !handshake_tick) |=> $stable(panel_led))
        else $error("sum changed without tick");
endmodule
bind loop_diag_counter_bank loop_diag_checker #(.EVT_N(EVT_N), .ERR_N(ERR_N)) CHK (.clock(clock), .rst_n(rst_n),
    .address_select_switch(address_select_switch), .event_strobe(event_strobe), .host_rx_strobe(host_rx_strobe),
    .host_tx_strobe(host_tx_strobe), .idle_pass_strobe(idle_pass_strobe), .hard_error_strobe(hard_error_strobe),
    .handshake_tick(handshake_tick), .panel_led(panel_led));

// File: tb/loop_event_source.sv
`timescale 1ns/10ps
module loop_event_source
    import loop_diag_pkg::*;
(
    // Clock
    input wire logic clock,
    // Strobes toward the bank
    output logic [EVT_NUM-1:0] event_strobe,
    output logic [ERR_NUM-1:0] hard_error_strobe,
    output logic host_rx_strobe,
    output logic host_tx_strobe,
    output logic idle_pass_strobe,
    output logic handshake_tick
);
    // Quiet from time zero
    initial begin
        {event_strobe, hard_error_strobe, host_rx_strobe, host_tx_strobe, idle_pass_strobe, handshake_tick} = '0;
    end
    // One-cycle pulse after gap+1 idle cycles; misc is {rx, tx, idle, tick}
    task automatic pulse(input int gap, input logic [EVT_NUM-1:0] ev, input logic [ERR_NUM-1:0] er,
        input logic [3:0] misc);
        repeat (gap + 1) @(negedge clock);
        event_strobe = ev;
        hard_error_strobe = er;
        {host_rx_strobe, host_tx_strobe, idle_pass_strobe, handshake_tick} = misc;
        @(negedge clock);
        {event_strobe, hard_error_strobe, host_rx_strobe, host_tx_strobe, idle_pass_strobe, handshake_tick} = '0;
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import loop_diag_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [SW_W-1:0] sw = 8'h00;
    logic [EVT_NUM-1:0] ev;
    logic [ERR_NUM-1:0] er;
    logic rx;
    logic tx;
    logic idle;
    logic tick;
    logic [LED_W-1:0] led;
    int n_errors = 0;
    int n_compared = 0;
    always #4 clock = ~clock;
    loop_event_source SRC (.clock(clock), .event_strobe(ev), .hard_error_strobe(er), .host_rx_strobe(rx),
        .host_tx_strobe(tx), .idle_pass_strobe(idle), .handshake_tick(tick));
    loop_diag_counter_bank DUT (.clock(clock), .rst_n(rst_n), .address_select_switch(sw), .event_strobe(ev),
        .host_rx_strobe(rx), .host_tx_strobe(tx), .idle_pass_strobe(idle), .hard_error_strobe(er),
        .handshake_tick(tick), .panel_led(led));
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Select a counter, wait out the display lag, compare
    task automatic view(input logic [7:0] addr, input logic [15:0] exp);
        @(negedge clock);
        sw = addr;
        repeat (2) @(negedge clock);
        n_compared++;
        if (led !== exp) begin
            n_errors++;
            $display("MISMATCH %0t at %h got %h want %h", $time, addr, led, exp);
        end
    endtask
    // Unassigned and assigned places read zero after reset
    task automatic t_reset();
        logic [7:0] a[7] = '{8'h00, 8'h2F, 8'h3F, 8'h52, 8'hFF, 8'h30, 8'h41};
        foreach (a[i])
            view(a[i], 16'h0000);
    endtask
    // Event i pulsed i+1 times, several at once, prompt and slow
    task automatic t_events();
        view(ADDR_EVT_FIRST, 16'h0000);
        for (int k = 0; k < EVT_NUM; k++)
            SRC.pulse(k % 2, '1 << k, '0, 4'h0);
        for (int i = 0; i < EVT_NUM; i++)
            view(8'((i < 2) ? 48 + i : 49 + i), 16'(i + 1));
    endtask
    // Error j pulsed j+1 times; sum only moves on the tick
    task automatic t_errors();
        view(ADDR_ERR_SUM, 16'h0000);
        for (int k = 0; k < ERR_NUM; k++)
            SRC.pulse(0, '0, '1 << k, 4'h0);
        view(ADDR_ERR_SUM, 16'h0000);
        for (int j = 0; j < ERR_NUM; j++)
            view(8'(65 + j), 16'(j + 1));
        view(ADDR_EVT_FIRST, 16'h0001);
        SRC.pulse(0, '0, '0, 4'h1);
        view(ADDR_ERR_SUM, 16'h0099);
        view(ADDR_ERR_FIRST, 16'h0001);
        repeat (255)
            SRC.pulse(0, '0, 17'h00001, 4'h0);
        view(ADDR_ERR_FIRST, 16'h0000);
        SRC.pulse(0, '0, '0, 4'h1);
        view(ADDR_ERR_SUM, 16'h0098);
    endtask
    // Receive nibble wraps past 15, transmit nibble separate
    task automatic t_nibble();
        view(ADDR_NIBBLES, 16'h0000);
        repeat (17)
            SRC.pulse(0, '0, '0, 4'h8);
        repeat (3)
            SRC.pulse(1, '0, '0, 4'h4);
        view(ADDR_NIBBLES, 16'h0013);
    endtask
    // Idle count carries into its second byte
    task automatic t_idle();
        view(ADDR_IDLE, 16'h0000);
        repeat (258)
            SRC.pulse(0, '0, '0, 4'h2);
        view(ADDR_IDLE, 16'h0102);
    endtask
    // Reset in mid-run clears every kind of counter, the sum too
    task automatic t_rerst();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        view(ADDR_IDLE, 16'h0000);
        view(ADDR_NIBBLES, 16'h0000);
        view(ADDR_EVT_LAST, 16'h0000);
        view(ADDR_ERR_LAST, 16'h0000);
        view(ADDR_ERR_SUM, 16'h0000);
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_events();
        t_errors();
        t_nibble();
        t_idle();
        t_rerst();
        report_and_stop();
    end
    // Run needs about 1300 cycles; give it plenty
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
endmodule
